/* design/usu_master_xfer.v */
`timescale 1ns/100ps
`include "usu_defines.vh"

// Overview of operation
// RL1: buffer write starts spi frame
// RL2: tx-empty sets on shifter load
// RL3: tx buffer apart from shifter
// RL4: early write overwrites pending byte
// RL5: only buffer write starts reception
// RL6: eight sampled bits load rx buffer
// RL7: rx-full sets on load, write-one clears
// RL8: load while rx-full flags overrun
// RL9: select line is a software output; this module has no select output
// RL10: i2c pins drive low or release
// RL11: trigger starts coded operation
// RL12: trigger sets busy; finish sets irq
// RL13: result reports completed operation
// RL14: irq clear zeroes result
// RL15: start pulls data low, clock high
// RL16: start precedes any transfer
// RL17: byte send done at shifter load
// RL18: ack low, nak high
// RL19: software checks ack before next byte
// RL20: stop raises data, clock high
// RL21: start without stop repeats start
// RL22: software forms address bytes
// RL23: i2c units are eight bits
// RL24: polarity sets idle clock level
// RL25: nine-bit spi adds command bit
// RL26: reserved code does nothing
// RL27: irq flags gated by enables
module usu_master_xfer #(
  parameter FIFO_W = `USU_FIFO_WIDTH,   // receive stream word width
  parameter FIFO_D = `USU_FIFO_DEPTH    // receive stream depth
) (
  // clock and reset
  input  wire       i_clk_sys,
  input  wire       i_rst,
  // configuration
  input  wire       i_mode_i2c,         // 1 i2c master, 0 spi master
  input  wire       i_lsb_first,
  input  wire       i_spi_clock_polarity,
  input  wire       i_spi_length_select,
  input  wire       i_spi_command_bit_level,
  input  wire       i_ie_tx_empty,
  input  wire       i_ie_rx_full,
  input  wire       i_ie_i2c,
  // software strobes
  input  wire       i_tx_wr,
  input  wire [7:0] i_tx_buffer_byte,
  input  wire       i_i2c_master_trigger,
  input  wire [2:0] i_i2c_master_op_code,
  input  wire       i_spi_tx_empty_clr,
  input  wire       i_spi_rx_full_clr,
  input  wire       i_overrun_clr,
  input  wire       i_i2c_irq_clr,
  // status
  output reg        o_spi_tx_empty_flag,
  output reg        o_spi_rx_full_flag,
  output reg        o_overrun_flag,
  output reg        o_i2c_master_busy,
  output reg        o_i2c_master_irq_flag,
  output reg  [2:0] o_i2c_master_result,
  output reg        o_i2c_bus_busy,
  output reg  [7:0] o_rx_buffer_byte,
  output reg        o_irq,
  // received byte stream
  output wire       o_rx_valid,
  output wire [7:0] o_rx_data,
  input  wire       i_rx_ready,
  // transfer clock source and spi pins
  input  wire       i_xfer_clk,
  output reg        o_serial_clock_pin,
  output reg        o_serial_data_out_pin,
  input  wire       i_serial_data_in_pin,
  // i2c open-drain pins
  output wire       o_i2c_scl_out,
  output reg        o_i2c_scl_oe,
  output wire       o_i2c_sda_out,
  output reg        o_i2c_sda_oe
);
  localparam [2:0] ST_IDLE = 3'h1; // waiting for work
  localparam [2:0] ST_SPI  = 3'h2; // spi frame running
  localparam [2:0] ST_I2C  = 3'h4; // i2c operation running

  // reverse bit order for lsb-first framing
  function [7:0] rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        rev8[k] = v[7-k];
      end
    end
  endfunction

  reg  [2:0] xclk_s_r; // transfer clock synchroniser
  reg        xclk_f_r; // agreed transfer clock level
  reg        tick_r; // one pulse per transfer clock rise
  reg  [2:0] sdi_s_r; // data-in synchroniser
  reg        sdi_f_r; // agreed data-in level
  reg  [2:0] state_r; // engine state, one-hot
  reg  [7:0] tx_buf_r; // one-byte transmit buffer
  reg        tx_full_r; // buffer holds an unsent byte
  reg  [8:0] txsh_r; // transmit shifter, msb leaves first
  reg  [7:0] rxsh_r; // receive shifter
  reg  [3:0] bitcnt_r; // bits left in this unit
  reg        half_r; // spi half-period phase
  reg  [1:0] step_r; // i2c step within a bit
  reg  [2:0] cur_op_r; // running i2c operation
  reg        pend_r; // accepted trigger awaiting engine
  reg  [2:0] pend_op_r; // its operation code
  reg        push_r; // byte into receive stream
  reg  [7:0] push_data_r; // that byte
  wire       fifo_ready; // stream has room
  wire       trig_ok; // trigger is accepted
  wire [7:0] rx_byte; // received byte in bit order
  wire [7:0] tx_ord; // buffer byte in bit order

  assign o_i2c_scl_out = 1'b0;          // open drain: only ever low
  assign o_i2c_sda_out = 1'b0;          // RL10
  assign rx_byte = i_lsb_first ? rev8(rxsh_r) : rxsh_r;
  assign tx_ord  = i_lsb_first ? rev8(tx_buf_r) : tx_buf_r;
  // reserved code and transfers before a start are dropped
  assign trig_ok = i_i2c_master_trigger & i_mode_i2c & ~o_i2c_master_busy
                 & (i_i2c_master_op_code != `USU_OP_RESV)          // RL26
                 & ((i_i2c_master_op_code == `USU_OP_START) | o_i2c_bus_busy); // RL16

  // pin synchronisers: a level counts once stages two and three agree
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      xclk_s_r <= 3'h0;
      xclk_f_r <= 1'b0;
      tick_r   <= 1'b0;
      sdi_s_r  <= 3'h7;
      sdi_f_r  <= 1'b1;
    end else begin
      xclk_s_r <= {xclk_s_r[1:0], i_xfer_clk};
      sdi_s_r  <= {sdi_s_r[1:0], i_serial_data_in_pin};
      if (xclk_s_r[1] == xclk_s_r[2]) begin
        xclk_f_r <= xclk_s_r[2];
      end
      if (sdi_s_r[1] == sdi_s_r[2]) begin
        sdi_f_r <= sdi_s_r[2];
      end
      tick_r <= (xclk_s_r[1] == xclk_s_r[2]) & xclk_s_r[2] & ~xclk_f_r;
    end
  end

  // interrupt request from enabled flags
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (o_spi_tx_empty_flag & i_ie_tx_empty)               // RL27
             | ((o_spi_rx_full_flag | o_overrun_flag) & i_ie_rx_full)
             | (o_i2c_master_irq_flag & i_ie_i2c);
    end
  end

  // transfer engine, buffers and flags; later assignments win
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r               <= ST_IDLE;
      tx_buf_r              <= `USU_RST_BYTE;
      tx_full_r             <= 1'b0;
      txsh_r                <= 9'h1FF;
      rxsh_r                <= `USU_RST_BYTE;
      bitcnt_r              <= 4'h0;
      half_r                <= 1'b0;
      step_r                <= 2'h0;
      cur_op_r              <= `USU_OP_START;
      pend_r                <= 1'b0;
      pend_op_r             <= `USU_OP_START;
      push_r                <= 1'b0;
      push_data_r           <= `USU_RST_BYTE;
      o_spi_tx_empty_flag   <= 1'b0;
      o_spi_rx_full_flag    <= 1'b0;
      o_overrun_flag        <= 1'b0;
      o_i2c_master_busy     <= 1'b0;
      o_i2c_master_irq_flag <= 1'b0;
      o_i2c_master_result   <= `USU_RST_RESULT;
      o_i2c_bus_busy        <= 1'b0;
      o_rx_buffer_byte      <= `USU_RST_BYTE;
      o_serial_clock_pin    <= 1'b0;
      o_serial_data_out_pin <= 1'b1;
      o_i2c_scl_oe          <= 1'b0;
      o_i2c_sda_oe          <= 1'b0;
    end else begin
      push_r <= 1'b0;
      // write-one clears come first so a same-cycle set wins
      if (i_spi_tx_empty_clr) o_spi_tx_empty_flag <= 1'b0;
      if (i_spi_rx_full_clr) o_spi_rx_full_flag <= 1'b0;             // RL7
      if (i_overrun_clr) o_overrun_flag <= 1'b0;
      if (i_i2c_irq_clr) begin
        o_i2c_master_irq_flag <= 1'b0;
        o_i2c_master_result   <= `USU_RES_START;                     // RL14
      end
      // accept a trigger and hold busy until it completes
      if (trig_ok) begin
        o_i2c_master_busy <= 1'b1;                                   // RL12
        pend_r            <= 1'b1;                                   // RL11
        pend_op_r         <= i_i2c_master_op_code;
      end
      case (state_r)
        ST_IDLE: begin
          o_serial_clock_pin <= i_spi_clock_polarity;                // RL24
          half_r             <= 1'b0;
          step_r             <= 2'h0;
          if (!i_mode_i2c && tx_full_r && fifo_ready) begin
            // only a buffer write launches an spi frame
            state_r             <= ST_SPI;                           // RL5
            tx_full_r           <= 1'b0;                             // RL1
            o_spi_tx_empty_flag <= 1'b1;                             // RL2
            if (i_spi_length_select) begin
              txsh_r   <= {i_spi_command_bit_level, tx_ord}; // RL25
              bitcnt_r <= `USU_BITS_CMD;
              o_serial_data_out_pin <= i_spi_command_bit_level;
            end else begin
              txsh_r   <= {tx_ord, 1'b1};
              bitcnt_r <= `USU_BITS_BYTE;
              o_serial_data_out_pin <= tx_ord[7];
            end
          end else if (i_mode_i2c && pend_r
                       && (pend_op_r != `USU_OP_RX || fifo_ready)) begin
            state_r  <= ST_I2C;
            pend_r   <= 1'b0;
            cur_op_r <= pend_op_r;
            bitcnt_r <= `USU_BITS_ACK;
            txsh_r   <= 9'h1FF;                  // released data line
            if (pend_op_r == `USU_OP_TX) begin
              // report as soon as the buffer reaches the shifter
              txsh_r                <= {tx_ord, 1'b1};
              bitcnt_r              <= `USU_BITS_BYTE;               // RL23
              tx_full_r             <= 1'b0;
              o_i2c_master_busy     <= 1'b0;                         // RL17
              o_i2c_master_irq_flag <= 1'b1;
              o_i2c_master_result   <= `USU_RES_TXE;                 // RL13
            end else if (pend_op_r == `USU_OP_RX) begin
              bitcnt_r <= `USU_BITS_BYTE;                            // RL23
            end else if (pend_op_r == `USU_OP_ACK) begin
              txsh_r <= 9'h0FF;                  // one low bit
            end
          end
        end
        ST_SPI: begin
          if (tick_r) begin
            if (!half_r) begin
              // leading edge: clock active, sample data in
              o_serial_clock_pin <= ~i_spi_clock_polarity;
              rxsh_r             <= {rxsh_r[6:0], sdi_f_r};          // RL6
              half_r             <= 1'b1;
            end else begin
              // trailing edge: clock idle, next bit out
              o_serial_clock_pin <= i_spi_clock_polarity;
              half_r             <= 1'b0;
              txsh_r             <= {txsh_r[7:0], 1'b1};
              o_serial_data_out_pin <= txsh_r[7]; // RL1
              if (bitcnt_r == 4'h1) begin
                state_r            <= ST_IDLE;
                o_rx_buffer_byte   <= rx_byte;                       // RL6
                push_r             <= 1'b1;
                push_data_r        <= rx_byte;
                o_spi_rx_full_flag <= 1'b1;                          // RL7
                if (o_spi_rx_full_flag) o_overrun_flag <= 1'b1;      // RL8
              end else begin
                bitcnt_r <= bitcnt_r - 4'h1;
              end
            end
          end
        end
        ST_I2C: begin
          if (tick_r) begin
            step_r <= step_r + 2'h1;
            if (cur_op_r == `USU_OP_START) begin
              // release data, release clock, data low, clock low
              case (step_r)
                2'h0: o_i2c_sda_oe <= 1'b0;
                2'h1: o_i2c_scl_oe <= 1'b0;
                2'h2: o_i2c_sda_oe <= 1'b1;                          // RL15
                default: begin
                  o_i2c_scl_oe          <= 1'b1;
                  state_r               <= ST_IDLE;
                  o_i2c_bus_busy        <= 1'b1;                     // RL21
                  o_i2c_master_busy     <= 1'b0;
                  o_i2c_master_irq_flag <= 1'b1;
                  o_i2c_master_result   <= `USU_RES_START;
                end
              endcase
            end else if (cur_op_r == `USU_OP_STOP) begin
              // data low, release clock, then release data
              case (step_r)
                2'h0: o_i2c_sda_oe <= 1'b1;
                2'h1: o_i2c_scl_oe <= 1'b0;
                default: begin
                  o_i2c_sda_oe          <= 1'b0;                     // RL20
                  state_r               <= ST_IDLE;
                  o_i2c_bus_busy        <= 1'b0;
                  o_i2c_master_busy     <= 1'b0;
                  o_i2c_master_irq_flag <= 1'b1;
                  o_i2c_master_result   <= `USU_RES_STOP;
                end
              endcase
            end else begin
              // one bit: set data, clock high, sample, clock low
              case (step_r)
                2'h0: o_i2c_sda_oe <= ~txsh_r[8];                    // RL10
                2'h1: o_i2c_scl_oe <= 1'b0;
                2'h2: rxsh_r       <= {rxsh_r[6:0], sdi_f_r};
                default: begin
                  o_i2c_scl_oe <= 1'b1;
                  txsh_r       <= {txsh_r[7:0], 1'b1};
                  if (bitcnt_r != 4'h1) begin
                    bitcnt_r <= bitcnt_r - 4'h1;
                  end else begin
                    state_r <= ST_IDLE;
                    if (cur_op_r != `USU_OP_TX) begin
                      o_i2c_master_busy     <= 1'b0;                 // RL12
                      o_i2c_master_irq_flag <= 1'b1;
                    end
                    if (cur_op_r == `USU_OP_RX) begin
                      o_rx_buffer_byte    <= rx_byte;
                      push_r              <= 1'b1;
                      push_data_r         <= rx_byte;
                      o_i2c_master_result <= `USU_RES_RXF;
                    end else if (cur_op_r == `USU_OP_ACKRX) begin
                      o_i2c_master_result <= rxsh_r[0] ? `USU_RES_NAKRX
                                                       : `USU_RES_ACKRX; // RL18
                    end else if (cur_op_r != `USU_OP_TX) begin
                      o_i2c_master_result <= `USU_RES_ACKTX;
                    end
                  end
                end
              endcase
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // a buffer write overwrites any byte not yet taken
      if (i_tx_wr) begin
        tx_buf_r  <= i_tx_buffer_byte;                               // RL3
        tx_full_r <= 1'b1;                                           // RL4
      end
    end
  end

  // receive stream buffer; full stalls new receiving transfers
  usu_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_rx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (push_r),
    .i_in_data   (push_data_r),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );
endmodule // usu_master_xfer

/* design/usu_defines.vh */
`ifndef USU_DEFINES_VH
`define USU_DEFINES_VH

// i2c trigger codes
`define USU_OP_START   3'h0
`define USU_OP_STOP    3'h1
`define USU_OP_TX      3'h2
`define USU_OP_RX      3'h3
`define USU_OP_ACK     3'h4
`define USU_OP_NAK     3'h5
`define USU_OP_ACKRX   3'h6
`define USU_OP_RESV    3'h7

// i2c result codes
`define USU_RES_START  3'h0
`define USU_RES_STOP   3'h1
`define USU_RES_TXE    3'h2
`define USU_RES_RXF    3'h3
`define USU_RES_ACKTX  3'h4
`define USU_RES_ACKRX  3'h5
`define USU_RES_NAKRX  3'h6

// bit counts per transfer unit
`define USU_BITS_BYTE  4'h8
`define USU_BITS_CMD   4'h9
`define USU_BITS_ACK   4'h1

// receive stream fifo shape
`define USU_FIFO_WIDTH 8
`define USU_FIFO_DEPTH 8

// reset values
`define USU_RST_BYTE   8'h00
`define USU_RST_RESULT 3'h0

`endif

/* design/usu_fifo.v */
`timescale 1ns/100ps
// first-word-fall-through fifo with a registered output stage
module usu_fifo #(
  parameter W = 8, // word width
  parameter D = 8  // storage depth, power of two
) (
  // clock and reset
  input  wire         i_clk_sys,
  input  wire         i_rst,
  // filling side
  input  wire         i_in_valid,
  input  wire [W-1:0] i_in_data,
  output wire         o_in_ready,
  // draining side
  output reg          o_out_valid,
  output reg  [W-1:0] o_out_data,
  input  wire         i_out_ready
);
  localparam AW = $clog2(D);
  localparam [AW:0] FULL_C = D;

  reg  [W-1:0]  mem_r [0:D-1]; // storage words
  reg  [AW-1:0] wr_ptr_r; // write index, wraps
  reg  [AW-1:0] rd_ptr_r; // read index, wraps
  reg  [AW:0]   cnt_r; // words held in storage
  wire          push; // word accepted
  wire          pop; // output word taken
  wire          load; // output stage may refill
  wire          take_mem; // refill from storage
  wire          bypass; // refill straight from input
  wire          write_mem; // input goes into storage

  assign o_in_ready = (cnt_r != FULL_C);
  assign push       = i_in_valid & o_in_ready;
  assign pop        = o_out_valid & i_out_ready;
  assign load       = ~o_out_valid | pop;
  assign take_mem   = load & (cnt_r != {(AW+1){1'b0}});
  assign bypass     = load & (cnt_r == {(AW+1){1'b0}}) & push;
  assign write_mem  = push & ~bypass;

  // pointers, count and output stage
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      cnt_r       <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data  <= {W{1'b0}};
    end else begin
      if (write_mem) begin
        mem_r[wr_ptr_r] <= i_in_data;
        wr_ptr_r        <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (take_mem) begin
        o_out_data <= mem_r[rd_ptr_r];
        rd_ptr_r   <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end else if (bypass) begin
        o_out_data <= i_in_data;
      end
      if (load) begin
        o_out_valid <= take_mem | bypass;
      end
      // count moves only with storage traffic
      if (write_mem & ~take_mem) begin
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      end else if (take_mem & ~write_mem) begin
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // usu_fifo

/* bench/usu_slave_model.sv */
`timescale 1ns/100ps
// far-side slave: spi echo of the previous frame, i2c data line with pull-up
module usu_slave_model (
  // spi side
  input  wire i_sck,     // serial clock from the master
  input  wire i_mosi,    // master data out
  input  wire i_cpol,    // idle clock level
  // i2c side
  input  wire i_i2c,     // bus runs as i2c
  input  wire i_sda_oe,  // master pulls data low
  input  wire i_ack_low, // slave pulls data low on command
  output wire o_din      // level the master reads back
);
  reg [7:0] sh_r   = 8'hA5; // slave shifter, first reply is arbitrary
  reg       bit_r  = 1'b0;  // bit taken on the leading edge
  reg       lead_r = 1'b0;  // leading edge seen
  // no select line exists, so the slave is always addressed
  always @(i_sck) begin
    if (!i_i2c && i_sck !== i_cpol && i_sck !== 1'bx) begin
      bit_r  = i_mosi;
      lead_r = 1'b1;
    end else if (!i_i2c && lead_r) begin
      sh_r   = {sh_r[6:0], bit_r};
      lead_r = 1'b0;
    end
  end
  // released i2c line reads high through the pull-up
  assign o_din = i_i2c ? ~(i_sda_oe | i_ack_low) : sh_r[7];
endmodule // usu_slave_model

/* bench/usu_master_xfer_properties.sv */
`timescale 1ns/100ps
module usu_master_xfer_properties (
  // clock, reset and configuration
  input wire       i_clk_sys, i_rst, i_mode_i2c, i_ie_tx_empty, i_ie_rx_full, i_ie_i2c,
  // software strobes
  input wire       i_i2c_master_trigger, i_spi_tx_empty_clr, i_spi_rx_full_clr, i_i2c_irq_clr,
  input wire [2:0] i_i2c_master_op_code,
  // status and pins
  input wire       o_spi_tx_empty_flag, o_spi_rx_full_flag, o_overrun_flag, o_irq,
  input wire       o_i2c_master_busy, o_i2c_master_irq_flag, o_i2c_bus_busy,
  input wire [2:0] o_i2c_master_result,
  input wire       o_i2c_scl_out, o_i2c_sda_out
);
  // trigger that the engine accepts
  wire       take = i_i2c_master_trigger & i_mode_i2c & ~o_i2c_master_busy &
                    (i_i2c_master_op_code != 3'h7) & ((i_i2c_master_op_code == 3'h0) | o_i2c_bus_busy);
  reg  [2:0] op_r; // code of the operation in flight
  wire [2:0] res_exp = (op_r == 3'h5) ? 3'h4 : op_r; // result for all but ack sampling
  // remember the accepted code until the next one
  always @(posedge i_clk_sys)
    if (i_rst) op_r <= 3'h0;
    else if (take) op_r <= i_i2c_master_op_code;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_pins_never_high: assert property (!o_i2c_scl_out && !o_i2c_sda_out)
    else $error("i2c pin level driven high");
  a_take_sets_busy: assert property (take |=> o_i2c_master_busy)
    else $error("accepted trigger left busy low");
  a_refused_stays_idle: assert property (i_i2c_master_trigger && !take && !o_i2c_master_busy
    && !i_i2c_irq_clr |=> !o_i2c_master_busy && $stable(o_i2c_master_result)
    && $stable(o_i2c_master_irq_flag)) else $error("refused trigger changed state");
  a_done_sets_irq: assert property ($fell(o_i2c_master_busy) |-> o_i2c_master_irq_flag)
    else $error("completion without irq flag");
  a_result_matches_op: assert property ($fell(o_i2c_master_busy) |-> (op_r == 3'h6)
    ? (o_i2c_master_result == 3'h5 || o_i2c_master_result == 3'h6)
    : (o_i2c_master_result == res_exp)) else $error("wrong result code");
  a_bus_state_after: assert property ($fell(o_i2c_master_busy) && op_r <= 3'h1
    |-> o_i2c_bus_busy == (op_r == 3'h0)) else $error("bus state wrong after start or stop");
  a_irq_clr_result: assert property (i_i2c_irq_clr && !o_i2c_master_busy
    |=> !o_i2c_master_irq_flag && o_i2c_master_result == 3'h0) else $error("irq clear failed");
  a_rx_full_sticky: assert property ($fell(o_spi_rx_full_flag) |-> $past(i_spi_rx_full_clr))
    else $error("rx full dropped without clear");
  a_tx_empty_sticky: assert property ($fell(o_spi_tx_empty_flag) |-> $past(i_spi_tx_empty_clr))
    else $error("tx empty dropped without clear");
  a_overrun_cause: assert property ($rose(o_overrun_flag) |-> $past(o_spi_rx_full_flag))
    else $error("overrun without full buffer");
  a_irq_follows_flags: assert property (!$past(i_rst) |-> o_irq == $past(
    (o_spi_tx_empty_flag & i_ie_tx_empty) | ((o_spi_rx_full_flag | o_overrun_flag) & i_ie_rx_full)
    | (o_i2c_master_irq_flag & i_ie_i2c))) else $error("irq request mismatch");
  c_ack_seen: cover property ($fell(o_i2c_master_busy) && op_r == 3'h6 && o_i2c_master_result == 3'h5);
  c_overrun_seen: cover property ($rose(o_overrun_flag));
  c_restart_seen: cover property ($fell(o_i2c_master_busy) && op_r == 3'h0 && $past(o_i2c_bus_busy));
endmodule // usu_master_xfer_properties
bind usu_master_xfer usu_master_xfer_properties i_usu_master_xfer_properties (.*);

/* bench/tb.sv */
`timescale 1ns/100ps
module tb;
  // clock, reset and transfer clock source
  reg        i_clk_sys = 1'b0, i_rst = 1'b1, i_xfer_clk = 1'b0;
  // configuration
  reg        i_mode_i2c = 1'b0, i_lsb_first = 1'b0, i_spi_clock_polarity = 1'b0;
  reg        i_spi_length_select = 1'b0, i_spi_command_bit_level = 1'b0;
  reg        i_ie_tx_empty = 1'b0, i_ie_rx_full = 1'b1, i_ie_i2c = 1'b1;
  // strobes
  reg        i_tx_wr = 1'b0, i_i2c_master_trigger = 1'b0, i_rx_ready = 1'b0;
  reg        i_spi_tx_empty_clr = 1'b0, i_spi_rx_full_clr = 1'b0;
  reg        i_overrun_clr = 1'b0, i_i2c_irq_clr = 1'b0, ack_low = 1'b0;
  reg  [7:0] i_tx_buffer_byte = 8'h00;
  reg  [2:0] i_i2c_master_op_code = 3'h0;
  // design outputs
  wire       o_spi_tx_empty_flag, o_spi_rx_full_flag, o_overrun_flag, o_i2c_master_busy;
  wire       o_i2c_master_irq_flag, o_i2c_bus_busy, o_irq, o_rx_valid, i_serial_data_in_pin;
  wire       o_serial_clock_pin, o_serial_data_out_pin, o_i2c_scl_out, o_i2c_scl_oe;
  wire       o_i2c_sda_out, o_i2c_sda_oe;
  wire [2:0] o_i2c_master_result;
  wire [7:0] o_rx_buffer_byte, o_rx_data;
  // bookkeeping; a row is {code, slave pulls low, result, bus busy}
  integer    num_errors = 0, samples_checked = 0, k, n;
  reg        hit;
  reg  [7:0] rows [0:8] = '{8'h01, 8'h45, 8'hDB, 8'hCD, 8'h67, 8'h89, 8'hA9, 8'h01, 8'h22};
  usu_master_xfer i_usu_master_xfer (.*);
  usu_slave_model i_usu_slave_model (.i_sck(o_serial_clock_pin), .i_mosi(o_serial_data_out_pin),
    .i_cpol(i_spi_clock_polarity), .i_i2c(i_mode_i2c), .i_sda_oe(o_i2c_sda_oe),
    .i_ack_low(ack_low), .o_din(i_serial_data_in_pin));
  // clocks
  initial forever #2 i_clk_sys = ~i_clk_sys;
  initial forever #24 i_xfer_clk = ~i_xfer_clk;
  // byte sent in spi frame i
  function [7:0] tx_of(input integer i);
    tx_of = 8'h3C ^ (8'h25 * i[7:0]);
  endfunction
  // one comparison
  task chk(input [15:0] got, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for irq flag (0), rx full (1) or overrun (2)
  task wait_sig(input integer s, output reg h);
    h = 1'b0;
    for (n = 0; n < 3000 && !h; n = n + 1) begin
      @(posedge i_clk_sys);
      #1 h = ((s == 0) ? o_i2c_master_irq_flag : (s == 1) ? o_spi_rx_full_flag : o_overrun_flag) === 1'b1;
    end
  endtask
  // write-one clear pulse: 0 irq, 1 rx full, 2 overrun, 3 tx empty
  task clr(input integer s);
    @(posedge i_clk_sys);
    {i_spi_tx_empty_clr, i_overrun_clr, i_spi_rx_full_clr, i_i2c_irq_clr} <= 4'h1 << s;
    @(posedge i_clk_sys);
    {i_spi_tx_empty_clr, i_overrun_clr, i_spi_rx_full_clr, i_i2c_irq_clr} <= 4'h0;
  endtask
  // buffer write
  task wr(input [7:0] b, input last);
    @(posedge i_clk_sys);
    i_tx_wr <= 1'b1;
    i_tx_buffer_byte <= b;
    if (last) @(posedge i_clk_sys) i_tx_wr <= 1'b0;
  endtask
  // trigger pulse with its code
  task trig(input [2:0] c);
    @(posedge i_clk_sys);
    i_i2c_master_trigger <= 1'b1;
    i_i2c_master_op_code <= c;
    @(posedge i_clk_sys);
    i_i2c_master_trigger <= 1'b0;
  endtask
  // counts and verdict
  task wrap_up;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys) #1 chk({o_spi_tx_empty_flag, o_spi_rx_full_flag, o_overrun_flag,
      o_i2c_master_busy, o_i2c_master_irq_flag, o_i2c_master_result, o_i2c_bus_busy, o_irq,
      o_rx_valid, o_i2c_scl_oe, o_i2c_sda_oe, o_serial_data_out_pin, o_serial_clock_pin}, 16'h0002);
    @(posedge i_clk_sys) i_spi_clock_polarity <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1 chk(o_serial_clock_pin, 1'b1);
    $display("reset and idle test done");
    // stalled stream; frame 9 finds fifo full
    for (k = 0; k < 10; k = k + 1) begin
      clr(3);
      i_mode_i2c <= (k == 0);
      if (k == 0) wr(8'h11, 1'b0);
      wr(tx_of(k), 1'b1);
      i_mode_i2c <= 1'b0;
      wait_sig((k == 3) ? 2 : 1, hit);
      chk(hit, k < 9);
      if (k < 9) chk(o_rx_buffer_byte, (k == 0) ? 8'hA5 : tx_of(k - 1));
      if (k < 9) chk(o_spi_tx_empty_flag, 1'b1);
      if (k != 2) clr(1);
    end
    $display("spi test done");
    @(posedge i_clk_sys) i_rx_ready <= 1'b1;
    #1;
    for (k = 0; k < 9; k = k + 1) begin
      for (n = 0; n < 40 && o_rx_valid !== 1'b1; n = n + 1) @(posedge i_clk_sys) #1;
      chk(o_rx_data, (k == 0) ? 8'hA5 : tx_of(k - 1));
      @(posedge i_clk_sys) #1;
    end
    wait_sig(1, hit);
    chk({hit, o_rx_buffer_byte}, {1'b1, tx_of(8)});
    clr(1);
    clr(2);
    $display("stream test done");
    @(posedge i_clk_sys) i_mode_i2c <= 1'b1;
    i_ie_tx_empty <= 1'b1;
    trig(3'h2);
    repeat (3) @(posedge i_clk_sys);
    #1 chk(o_i2c_master_busy, 1'b0);
    wr(8'hA0, 1'b1);
    // one row per i2c operation
    for (k = 0; k < 9; k = k + 1) begin
      @(posedge i_clk_sys);
      ack_low <= rows[k][4];
      trig(rows[k][7:5]);
      #1 chk(o_i2c_master_busy, 1'b1);
      wait_sig(0, hit);
      chk({hit, o_i2c_master_busy, o_i2c_master_result, o_i2c_bus_busy}, {2'b10, rows[k][3:0]});
      if (k == 4) chk(o_rx_buffer_byte, 8'hFF);
      clr(0);
      #1 chk({o_i2c_master_irq_flag, o_i2c_master_result}, 4'h0);
      if (k == 0) begin
        trig(3'h7);
        repeat (3) @(posedge i_clk_sys);
        #1 chk({o_i2c_master_busy, o_i2c_master_irq_flag, o_i2c_master_result}, 5'h00);
      end
    end
    trig(3'h3);
    repeat (3) @(posedge i_clk_sys);
    #1 chk(o_i2c_master_busy, 1'b0);
    $display("i2c test done");
    wrap_up;
  end
endmodule // tb
